// *** monitor_display_map.svh ***
// Constants for the monitor-mode display: offsets, fields, reset values, timing.
`ifndef MONITOR_DISPLAY_MAP_SVH
`define MONITOR_DISPLAY_MAP_SVH
// Register byte offsets
`define OFS_CTRL        4'h0
`define OFS_RATIO       4'h4
`define OFS_SPEED       4'h8
`define OFS_LOAD        4'hc
// Control fields
`define CTRL_SCREEN_LSB 0
`define CTRL_INIT_LSB   4
`define CTRL_HOLD_BIT   8
`define CTRL_ARST_BIT   9
`define CTRL_ACLR_BIT   10
`define CTRL_WCLR_BIT   11
`define CTRL_NEXT_BIT   12
// Reset values
`define CTRL_RESET      32'h0000_0000
`define RATIO_UNITY     16'h0064
// Load factor limits in percent
`define LOAD_MIN        8'h28
`define LOAD_MAX        8'hc8
// Ratio range thresholds, hundredths; display maximum
`define RATIO_10        24'h0003e8
`define RATIO_100       24'h002710
`define RATIO_1000      24'h0186a0
`define DISP_MAX        14'h270f
// Blink half period
`define BLINK_MS        500
`define CLK_KHZ         125000
`endif

// *** monitor_display_pkg.sv ***
// Types for the monitor-mode display.
`default_nettype none
package monitor_display_pkg;
	typedef enum logic [2:0] {SCR_SPEED, SCR_LOAD, SCR_DATA, SCR_ALARM, SCR_WARN, SCR_IO} screen_t;
	typedef struct packed {
		logic [3:0]  mode;
		logic [15:0] value;
		logic [1:0]  point;
		logic        dash;
		logic        hold;
		logic        blink;
	} disp_t;
endpackage : monitor_display_pkg
`default_nettype wire

// *** motor_monitor_display.sv ***
// Monitor-mode display selection and formatting with an Avalon-MM register port.
//
// Behaviour
// - Speed divided by reduction ratio when set
// - Speed multiplied by increasing ratio when set
// - Unity increasing ratio selects reduction ratio
// - Load factor from motor shaft torque
// - Load one-percent steps; dash below forty
// - Holding pattern while position keeping enabled
// - Show selected operation data number
// - Alarm code, reset and history clear
// - Warning code and history clear
// - One segment per I/O signal, lit when on
// - Speed screen at power-up, configurable
// - Decimal point placed by reduction ratio range; none with increasing ratio
// - Conveyor speed is motor speed over ratio
// - Alarm screen first; keys move away
// - Blink while alarm shown elsewhere
//
// The Avalon-MM register port and the register addresses were decided locally.
`include "monitor_display_map.svh"
`default_nettype none
module motor_monitor_display
	import monitor_display_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [12:0] motor_speed,
	input  wire logic [7:0]  motor_load,
	input  wire logic [1:0]  data_select,
	input  wire logic        alarm_active,
	input  wire logic [7:0]  alarm_code,
	input  wire logic        warning_active,
	input  wire logic [7:0]  warning_code,
	input  wire logic [4:0]  io_inputs,
	input  wire logic [4:0]  io_outputs,
	input  wire logic        key_mode,
	input  wire logic        key_func,
	output logic             alarm_reset,
	output logic             alarm_hist_clear,
	output logic             warning_hist_clear,
	output disp_t            disp
);
	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	localparam int unsigned BLINK_CYC = `BLINK_MS * `CLK_KHZ;
	logic [1:0]  sel_s1_reg, sel_s2_reg;
	logic [4:0]  in_s1_reg, in_s2_reg;
	logic [1:0]  key_s1_reg, key_s2_reg, key_s3_reg;
	always_ff @(posedge clk) begin
		sel_s1_reg <= data_select;
		sel_s2_reg <= sel_s1_reg;
		in_s1_reg  <= io_inputs;
		in_s2_reg  <= in_s1_reg;
		key_s1_reg <= {key_func, key_mode};
		key_s2_reg <= key_s1_reg;
		key_s3_reg <= key_s2_reg;
	end
	wire key_press = |(key_s2_reg & ~key_s3_reg);

	// ********************************************************************
	// Register port
	// ********************************************************************
	logic [31:0] ctrl_reg;
	logic [31:0] ratio_reg;
	logic        rd_done_reg;
	wire  wr_ctrl  = write && (address == `OFS_CTRL);
	wire  wr_ratio = write && (address == `OFS_RATIO);
	wire  [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	// Writes finish at once; reads take one extra cycle for registered data
	assign waitrequest = read && !rd_done_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg  <= `CTRL_RESET;
			ratio_reg <= {`RATIO_UNITY, `RATIO_UNITY};
		end else begin
			if (wr_ctrl)
				ctrl_reg  <= (ctrl_reg & ~be_mask) | (writedata & be_mask);
			if (wr_ratio)
				ratio_reg <= (ratio_reg & ~be_mask) | (writedata & be_mask);
		end
	end
	// Command bits act as one-cycle pulses; ctrl_reg keeps them, but reads mask them off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alarm_reset        <= 1'b0;
			alarm_hist_clear   <= 1'b0;
			warning_hist_clear <= 1'b0;
		end else begin
			alarm_reset        <= wr_ctrl && writedata[`CTRL_ARST_BIT] && byteenable[1] && alarm_active;
			alarm_hist_clear   <= wr_ctrl && writedata[`CTRL_ACLR_BIT] && byteenable[1];
			warning_hist_clear <= wr_ctrl && writedata[`CTRL_WCLR_BIT] && byteenable[1];
		end
	end

	// ********************************************************************
	// Speed scaling
	// ********************************************************************
	wire  [15:0] red_ratio = ratio_reg[15:0];
	wire  [15:0] inc_ratio = ratio_reg[31:16];
	wire         use_inc   = (inc_ratio != `RATIO_UNITY);
	wire  [15:0] ratio     = use_inc ? inc_ratio : red_ratio;
	// Point shift: 10^k extra digits for larger ratios keep four significant digits
	wire  [1:0]  point     = ({8'h00, ratio} >= `RATIO_1000) ? 2'd3 :
	                          ({8'h00, ratio} >= `RATIO_100)  ? 2'd2 :
	                          ({8'h00, ratio} >= `RATIO_10)   ? 2'd1 : 2'd0;
	wire  [15:0] pscale    = (point == 2'd3) ? 16'h03e8 : (point == 2'd2) ? 16'h0064 :
	                          (point == 2'd1) ? 16'h000a : 16'h0001;
	// Reduction: speed*100*10^p/ratio; divide by zero treated as unity
	wire  [39:0] num_red   = 40'({27'h0, motor_speed} * 40'h64 * {24'h0, pscale});
	wire  [39:0] den       = (ratio == 16'h0000) ? 40'h64 : {24'h0, ratio};
	wire  [39:0] q_red     = num_red / den;
	// Increase: speed*ratio/100 (ratio in hundredths); point unused for product
	wire  [39:0] q_inc     = 40'({27'h0, motor_speed} * {24'h0, ratio}) / 40'h64;
	wire  [39:0] q_sel     = use_inc ? q_inc : q_red;
	wire  [15:0] spd_sat   = (q_sel > {26'h0, `DISP_MAX}) ? {2'b00, `DISP_MAX} : q_sel[15:0];
	// A raised speed is a plain product, so it carries no point; panel and register agree
	wire  [1:0]  shown_pt  = use_inc ? 2'd0 : point;

	// ********************************************************************
	// Screen selection
	// ********************************************************************
	screen_t scr_reg, scr_next;
	logic    init_done_reg;
	logic    alarm_d_reg;
	wire [2:0] init_scr = ctrl_reg[`CTRL_INIT_LSB +: 3];
	wire       new_alarm = alarm_active && !alarm_d_reg;
	wire       advance   = key_press || (wr_ctrl && writedata[`CTRL_NEXT_BIT] && byteenable[1]);
	// Until the first alarm, key or next command the screen follows the power-up setting, so
	// software may load that setting after reset and the panel still opens on it
	always_comb begin
		scr_next = scr_reg;
		if (new_alarm)
			scr_next = SCR_ALARM;
		else if (!init_done_reg && !advance)
			scr_next = (init_scr <= 3'd5) ? screen_t'(init_scr) : SCR_SPEED;
		else if (advance) begin
			case (scr_reg)
				SCR_SPEED: scr_next = SCR_LOAD;
				SCR_LOAD:  scr_next = SCR_DATA;
				SCR_DATA:  scr_next = SCR_ALARM;
				SCR_ALARM: scr_next = SCR_WARN;
				SCR_WARN:  scr_next = SCR_IO;
				SCR_IO:    scr_next = SCR_SPEED;
				default:   scr_next = SCR_SPEED;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scr_reg       <= SCR_SPEED;
			init_done_reg <= 1'b0;
			alarm_d_reg   <= 1'b0;
		end else begin
			scr_reg       <= scr_next;
			init_done_reg <= init_done_reg || new_alarm || advance;
			alarm_d_reg   <= alarm_active;
		end
	end

	// ********************************************************************
	// Blink timer
	// ********************************************************************
	logic [26:0] blink_cnt_reg;
	logic        blink_ph_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			blink_cnt_reg <= 27'h0;
			blink_ph_reg  <= 1'b1; // Flag phase first, so a fresh alarm shows at once
		end else if (blink_cnt_reg == 27'(BLINK_CYC - 1)) begin
			blink_cnt_reg <= 27'h0;
			blink_ph_reg  <= !blink_ph_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 27'h1;
		end
	end

	// ********************************************************************
	// Display formatting
	// ********************************************************************
	wire [7:0] load_clip = (motor_load > `LOAD_MAX) ? `LOAD_MAX : motor_load;
	wire       hold_en   = ctrl_reg[`CTRL_HOLD_BIT];
	disp_t     disp_next;
	always_comb begin
		disp_next       = '0;
		disp_next.mode  = {1'b0, scr_reg};
		disp_next.blink = alarm_active && (scr_reg != SCR_ALARM) && blink_ph_reg;
		case (scr_reg)
			SCR_SPEED: begin
				disp_next.value = spd_sat;
				disp_next.point = shown_pt;
			end
			SCR_LOAD: begin
				disp_next.hold  = hold_en;
				disp_next.dash  = !hold_en && (motor_load < `LOAD_MIN);
				disp_next.value = (hold_en || motor_load < `LOAD_MIN) ? 16'h0 : {8'h0, load_clip};
			end
			SCR_DATA:  disp_next.value = {14'h0, sel_s2_reg};
			SCR_ALARM: disp_next.value = alarm_active ? {8'h0, alarm_code} : 16'h0;
			SCR_WARN:  disp_next.value = warning_active ? {8'h0, warning_code} : 16'h0;
			SCR_IO:    disp_next.value = {6'h0, io_outputs, in_s2_reg};
			default:   disp_next.value = 16'h0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			disp <= '0;
		else
			disp <= disp_next;
	end

	// Read data, registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readdata    <= 32'h0;
			rd_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= read && !rd_done_reg;
			case (address)
				`OFS_CTRL:  readdata <= ctrl_reg & 32'h0000_01ff;
				`OFS_RATIO: readdata <= ratio_reg;
				`OFS_SPEED: readdata <= {14'h0, shown_pt, spd_sat};
				`OFS_LOAD:  readdata <= {21'h0, scr_reg, load_clip};
				default:    readdata <= 32'h0;
			endcase
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	AST_IO_SEG: assert property (@(posedge clk) disable iff (!rst_n)
		scr_reg == SCR_IO |=> disp.value[9:5] == $past(io_outputs)) else $error("io segments wrong");
	AST_DASH: assert property (@(posedge clk) disable iff (!rst_n)
		scr_reg == SCR_LOAD && !hold_en && motor_load < 8'h28 |=> disp.dash) else $error("dash missing");
	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		scr_reg == SCR_LOAD && hold_en |=> disp.hold && !disp.dash) else $error("hold pattern missing");
	AST_LOAD_MAX: assert property (@(posedge clk) disable iff (!rst_n)
		disp.value <= 16'd200 || disp.mode != 4'(SCR_LOAD)) else $error("load over 200");
	AST_ALARM_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(alarm_active) |=> scr_reg == SCR_ALARM) else $error("alarm not shown");
	AST_BLINK: assert property (@(posedge clk) disable iff (!rst_n)
		!alarm_active |=> !disp.blink) else $error("blink without alarm");
	AST_SAT: assert property (@(posedge clk) disable iff (!rst_n)
		disp.mode == 4'(SCR_SPEED) |-> disp.value <= 16'd9999) else $error("speed overflow");
	AST_RATIO_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		inc_ratio == 16'd100 |-> ratio == red_ratio) else $error("wrong ratio chosen");
	AST_ARST: assert property (@(posedge clk) disable iff (!rst_n)
		alarm_reset |-> $past(wr_ctrl)) else $error("alarm reset without write");
	AST_POINT: assert property (@(posedge clk) disable iff (!rst_n)
		ratio < 16'd1000 |-> point == 2'd0) else $error("point misplaced");
	AST_DATA: assert property (@(posedge clk) disable iff (!rst_n)
		scr_reg == SCR_DATA |=> disp.value[1:0] == $past(sel_s2_reg)) else $error("data number wrong");
endmodule : motor_monitor_display
`default_nettype wire

// *** panel_operator.sv ***
// Front-panel operator model: presses the mode or function key.
`default_nettype none
module panel_operator (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic push_mode,
	input  wire logic push_func,
	output logic      key_mode,
	output logic      key_func
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold_reg;
	logic       func_reg;
	// A press lasts six cycles so the two-flop pin synchroniser cannot miss it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_reg <= 3'h0;
			func_reg <= 1'b0;
		end else if (hold_reg != 3'h0) begin
			hold_reg <= hold_reg - 3'h1;
		end else if (push_mode || push_func) begin
			hold_reg <= 3'h6;
			func_reg <= push_func;
		end
	end
	assign key_mode = (hold_reg != 3'h0) && !func_reg;
	assign key_func = (hold_reg != 3'h0) && func_reg;
endmodule : panel_operator
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the monitor-mode display.
`default_nettype none
module tb
	import monitor_display_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, push_mode = 1'b0, push_func = 1'b0;
	logic [3:0]  address = 4'h0, byteenable = 4'hf;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic        waitrequest, alarm_reset, alarm_hist_clear, warning_hist_clear, key_mode, key_func;
	logic [12:0] motor_speed = 13'h514;
	logic [7:0]  motor_load = 8'h0, alarm_code = 8'h0, warning_code = 8'h0;
	logic [1:0]  data_select = 2'h0;
	logic        alarm_active = 1'b0, warning_active = 1'b0;
	logic [4:0]  io_inputs = 5'h0, io_outputs = 5'h0;
	disp_t       disp;
	int          num_errors = 0, check_count = 0, cycles = 0;
	// Ratio words {increasing, reduction} and the expected {point, value} at 1300 r/min
	logic [31:0] ratio_tab [7] = '{32'h0064_0064, 32'h0064_03e7, 32'h0064_03e8, 32'h0064_18e2,
		32'h0064_61a8, 32'h00fa_0064, 32'h2710_61a8};
	logic [17:0] spd_tab [7] = '{18'h00514, 18'h00082, 18'h10514, 18'h100cc, 18'h20208, 18'h00cb2, 18'h0270f};
	motor_monitor_display motor_monitor_display_i (.clk, .rst_n, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .motor_speed, .motor_load, .data_select, .alarm_active,
		.alarm_code, .warning_active, .warning_code, .io_inputs, .io_outputs, .key_mode, .key_func,
		.alarm_reset, .alarm_hist_clear, .warning_hist_clear, .disp);
	panel_operator panel_operator_i (.clk, .rst_n, .push_mode, .push_func, .key_mode, .key_func);
	always #4 clk = ~clk;
	// A hang is cut short well beyond the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request held until waitrequest is sampled low; read data taken at that edge
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : av
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic key(input logic f);
		@(posedge clk);
		push_mode <= !f;
		push_func <= f;
		@(posedge clk);
		push_mode <= 1'b0;
		push_func <= 1'b0;
		settle(16);
	endtask : key
	// Command write; its pulse must stand only in the cycle after the write edge
	task automatic pulse(input int b, input logic exp);
		av(1'b1, 4'h0, 32'h1 << b);
		#1;
		check({alarm_reset, alarm_hist_clear, warning_hist_clear} >> (11 - b), {31'h0, exp});
		settle(1);
		check({alarm_reset, alarm_hist_clear, warning_hist_clear}, 32'h0);
	endtask : pulse
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_power;
		settle(2);
		check(disp.mode, 32'h0);
		av(1'b1, 4'h0, 32'h10);
		settle(3);
		check(disp.mode, 32'h1);
		av(1'b0, 4'h0, 32'h0);
		check(rd, 32'h10);
		av(1'b1, 4'h0, 32'h0);
		settle(3);
		check(disp.mode, 32'h0);
		av(1'b0, 4'h2, 32'h0);
		check(rd, 32'h0);
		$display("power-up done");
	endtask : t_power
	task automatic t_speed;
		for (int i = 0; i < 7; i++) begin
			av(1'b1, 4'h4, ratio_tab[i]);
			settle(4);
			av(1'b0, 4'h8, 32'h0);
			check(rd[17:0], spd_tab[i]);
			check({disp.point, disp.value}, spd_tab[i]);
		end
		$display("speed done");
	endtask : t_speed
	task automatic t_alarm;
		@(posedge clk);
		alarm_code <= 8'h2a;
		alarm_active <= 1'b1;
		settle(8);
		check({disp.mode, disp.value[7:0]}, 32'h32a);
		pulse(9, 1'b1);
		pulse(10, 1'b1);
		key(1'b0);
		check({disp.mode, disp.blink}, 32'h9);
		@(posedge clk);
		alarm_active <= 1'b0;
		settle(4);
		check(disp.blink, 32'h0);
		pulse(9, 1'b0);
		$display("alarm done");
	endtask : t_alarm
	task automatic t_warn_io;
		@(posedge clk);
		warning_code <= 8'h11;
		warning_active <= 1'b1;
		settle(4);
		check(disp.value[7:0], 32'h11);
		pulse(11, 1'b1);
		key(1'b0);
		@(posedge clk);
		io_inputs <= 5'h15;
		io_outputs <= 5'h0a;
		settle(6);
		check({disp.mode, disp.value[9:0]}, {22'h5, 10'h155});
		av(1'b1, 4'h0, 32'h1000);
		settle(3);
		check(disp.mode, 32'h0);
		$display("warning and io done");
	endtask : t_warn_io
	task automatic t_load_data;
		key(1'b0);
		@(posedge clk);
		motor_load <= 8'h27;
		settle(4);
		check({disp.mode, disp.dash}, 32'h3);
		@(posedge clk);
		motor_load <= 8'h28;
		settle(4);
		av(1'b0, 4'hc, 32'h0);
		check({rd[10:0], disp.dash}, {20'h0, 11'h128, 1'b0});
		@(posedge clk);
		motor_load <= 8'hfa;
		settle(4);
		av(1'b0, 4'hc, 32'h0);
		check({rd[7:0], disp.value}, 32'h00c8_00c8);
		av(1'b1, 4'h0, 32'h100);
		settle(3);
		check(disp.hold, 32'h1);
		key(1'b1);
		@(posedge clk);
		data_select <= 2'h3;
		settle(6);
		check({disp.mode, disp.value}, {16'h2, 16'h3});
		$display("load and data done");
	endtask : t_load_data
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_power();
		t_speed();
		t_alarm();
		t_warn_io();
		t_load_data();
		conclude();
	end
endmodule : tb
`default_nettype wire
